// ===== logic/phc_ctrl.sv
// Power control core: request inputs, start-up sequence, host signals
`timescale 1ns/1ns
module phc_ctrl
  import phc_pkg::*;
#(
  parameter int unsigned P_RST_DLY_CYC = RST_DLY_CYC,
  parameter int unsigned P_FLT_RST_CYC = FLT_RST_CYC,
  parameter int unsigned P_FLT_OFF_CYC = FLT_OFF_CYC,
  parameter int unsigned P_HOLD_OFF_CYC = HOLD_OFF_CYC,
  parameter int unsigned P_SLOT_CYC = SLOT_CYC,
  parameter int unsigned P_SLOW_CYC = SLOW_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic POWER_ON_REQUEST,
  input wire logic LOW_POWER_REQUEST,
  input wire logic FAULT_IN,
  input wire logic [7:0] FUSE_CFG,
  input wire logic [4:0] FUSE_SEQ_LAST,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic HOST_RESET_OUT_N_O,
  output logic HOST_RESET_OUT_N_OE,
  output logic SHUTDOWN_WARNING_N_O,
  output logic SHUTDOWN_WARNING_N_OE,
  output logic FAULT_IRQ_OUT_N_O,
  output logic FAULT_IRQ_OUT_N_OE,
  output logic [4:0] REG_SLOT,
  output logic STANDBY_ACTIVE,
  output logic POWERED
);
  phc_reg_if rif ();
  phc_state_e st_reg, st_next;
  // Sync bits: 0 power-on, 1 low-power, 2 fault, 3 SCL, 4 SDA
  logic [4:0] s1_reg, s2_reg, s3_reg, stb_reg, stb_next;
  logic pwr_q_reg, flt_q_reg;
  logic [31:0] tmr_reg, tmr_next, flt_reg, flt_next, hold_reg, hold_next;
  logic [4:0] slot_reg, slot_next;
  logic rst_oe_reg, rst_oe_next, sdw_oe_reg, sdw_oe_next;
  logic seen_reg, seen_next, stby_reg, stby_next;
  logic powered_reg, powered_next;
  logic flag_reg, flag_next, irq_oe_reg, irq_oe_next;
  logic [7:0] ctrl_reg, ctrl_next, fuse_reg;
  logic [4:0] seq_reg, seq_next, fseq_reg;
  logic frm_reg, frm_next, mask_reg, mask_next;
  logic pwr, lpr, flt, trial, edge_sel, lp_inv, fmode, on_evt, off_evt;
  logic [4:0] last;

  // Counter step that sticks at the top instead of wrapping
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hFFFF_FFFF) ? v : v + 32'h1;
  endfunction

  function automatic logic wr_hit(input logic [7:0] ofs);
    return rif.wr && rif.addr == ofs;
  endfunction

  // Three-stage synchroniser; a change counts when stages two and three agree
  always_comb begin
    stb_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stb_reg);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s1_reg <= 5'h18;
      s2_reg <= 5'h18;
      s3_reg <= 5'h18;
      stb_reg <= 5'h18;
      pwr_q_reg <= 1'b0;
      flt_q_reg <= 1'b0;
    end else begin
      s1_reg <= {SDA_I, SCL, FAULT_IN, LOW_POWER_REQUEST, POWER_ON_REQUEST};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stb_reg <= stb_next;
      pwr_q_reg <= stb_reg[0];
      flt_q_reg <= stb_reg[2];
    end
  end

  assign pwr = stb_reg[0];
  assign lpr = stb_reg[1];
  assign flt = stb_reg[2];
  assign rif.scl = stb_reg[3];
  assign rif.sda = stb_reg[4];

  // Trial mode takes settings from registers, else from captured fuses
  assign trial = ctrl_reg[B_TRIAL];
  assign edge_sel = trial ? ctrl_reg[B_EDGE_SEL] : fuse_reg[B_EDGE_SEL];
  assign lp_inv = trial ? ctrl_reg[B_LP_INV] : fuse_reg[B_LP_INV];
  assign fmode = trial ? frm_reg : fuse_reg[B_FAULT_MODE];
  assign last = trial ? seq_reg : fseq_reg;

  // Turn-on and turn-off events from the power-on request; turn-off also after a long fault in fault mode
  assign on_evt = edge_sel ? (pwr_q_reg & ~pwr) : pwr;
  assign off_evt = (!edge_sel && !pwr)
    || (edge_sel && hold_reg >= P_HOLD_OFF_CYC)
    || (fmode && flt_reg > P_FLT_OFF_CYC);

  // Fault persistence and button hold timers
  always_comb begin
    // Held at zero while off, so a restart into a lasting fault times it afresh
    flt_next = (flt && st_reg != ST_OFF) ? sat_inc(flt_reg) : 32'h0;
    hold_next = (edge_sel && !pwr && st_reg != ST_OFF) ? sat_inc(hold_reg) : 32'h0;
  end

  // Power state machine; one shared timer paces slots, delay and warning
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg + 32'h1;
    slot_next = slot_reg;
    rst_oe_next = rst_oe_reg;
    sdw_oe_next = 1'b0;
    seen_next = seen_reg | (flt && (st_reg inside {ST_SEQ, ST_RDLY}));
    unique case (st_reg)
      ST_OFF: begin
        tmr_next = 32'h0;
        rst_oe_next = 1'b1;
        if (on_evt) begin
          st_next = ST_SEQ;
          slot_next = 5'h00;
          seen_next = flt;
        end
      end
      ST_SEQ, ST_RDLY, ST_ON: begin
        if (off_evt) begin
          st_next = ST_WARN;
          tmr_next = 32'h0;
          rst_oe_next = 1'b1;
          sdw_oe_next = 1'b1;
        end else if (st_reg == ST_SEQ) begin
          if (slot_reg == last) begin
            st_next = ST_RDLY;
            tmr_next = 32'h0;
          end else if (tmr_reg == P_SLOT_CYC - 1) begin
            slot_next = slot_reg + 5'h01;
            tmr_next = 32'h0;
          end
        end else if (st_reg == ST_RDLY) begin
          if (tmr_reg == P_RST_DLY_CYC - 1) begin
            st_next = ST_ON;
            rst_oe_next = fmode && seen_reg;
          end
        end else begin
          tmr_next = 32'h0;
          // Fault mode pulls reset after a persistent fault, anytime
          if (fmode && flt_reg >= P_FLT_RST_CYC) begin
            rst_oe_next = 1'b1;
          end else if (fmode && !flt && !seen_reg) begin
            rst_oe_next = 1'b0;
          end else if (!fmode) begin
            rst_oe_next = 1'b0;
          end
        end
      end
      ST_WARN: begin
        // Exactly one slow-clock period, then released in off
        sdw_oe_next = 1'b1;
        if (tmr_reg == P_SLOW_CYC - 1) begin
          st_next = ST_OFF;
          sdw_oe_next = 1'b0;
          slot_next = 5'h00;
        end
      end
    endcase
    stby_next = (st_next == ST_ON) && (lpr ^ lp_inv);
    powered_next = (st_next != ST_OFF);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= ST_OFF;
      powered_reg <= 1'b0;
      tmr_reg <= 32'h0;
      flt_reg <= 32'h0;
      hold_reg <= 32'h0;
      slot_reg <= 5'h00;
      rst_oe_reg <= 1'b1;
      sdw_oe_reg <= 1'b0;
      seen_reg <= 1'b0;
      stby_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      flt_reg <= flt_next;
      hold_reg <= hold_next;
      slot_reg <= slot_next;
      rst_oe_reg <= rst_oe_next;
      sdw_oe_reg <= sdw_oe_next;
      seen_reg <= seen_next;
      stby_reg <= stby_next;
      powered_reg <= powered_next;
    end
  end

  // Registers; a new fault wins over a clear in the same cycle
  always_comb begin
    ctrl_next = wr_hit(OFS_CTRL) ? rif.wdata : ctrl_reg;
    seq_next = wr_hit(OFS_SEQ) ? rif.wdata[4:0] : seq_reg;
    frm_next = wr_hit(OFS_FRM) ? rif.wdata[B_FRM_EN] : frm_reg;
    mask_next = wr_hit(OFS_MASK) ? rif.wdata[B_MASK] : mask_reg;
    flag_next = (flt & ~flt_q_reg)
      | (flag_reg & ~(wr_hit(OFS_IRQ) & rif.wdata[B_IRQ_FLAG]));
    irq_oe_next = flag_next & ~mask_next;
    unique case (rif.addr)
      OFS_CTRL: rif.rdata = ctrl_reg;
      OFS_SEQ: rif.rdata = {3'h0, seq_reg};
      OFS_IRQ: rif.rdata = {6'h00, flt, flag_reg};
      OFS_MASK: rif.rdata = {7'h00, mask_reg};
      OFS_FRM: rif.rdata = {7'h00, frm_reg};
      default: rif.rdata = 8'h00;
    endcase
  end

  // Fuse word is a strap, captured while reset is held
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_reg <= RST_CTRL;
      seq_reg <= RST_SEQ;
      frm_reg <= RST_FRM;
      mask_reg <= RST_MASK;
      flag_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
      fuse_reg <= FUSE_CFG;
      fseq_reg <= FUSE_SEQ_LAST;
    end else begin
      ctrl_reg <= ctrl_next;
      seq_reg <= seq_next;
      frm_reg <= frm_next;
      mask_reg <= mask_next;
      flag_reg <= flag_next;
      irq_oe_reg <= irq_oe_next;
    end
  end

  phc_i2c_slave u_port (
    .clk(CLK),
    .srst(SRST),
    .bus(rif.port)
  );

  // Open-drain pins only ever pull low
  assign SDA_O = 1'b0;
  assign SDA_OE = rif.sda_oe;
  assign HOST_RESET_OUT_N_O = 1'b0;
  assign HOST_RESET_OUT_N_OE = rst_oe_reg;
  assign SHUTDOWN_WARNING_N_O = 1'b0;
  assign SHUTDOWN_WARNING_N_OE = sdw_oe_reg;
  assign FAULT_IRQ_OUT_N_O = 1'b0;
  assign FAULT_IRQ_OUT_N_OE = irq_oe_reg;
  assign REG_SLOT = slot_reg;
  assign STANDBY_ACTIVE = stby_reg;
  assign POWERED = powered_reg;

  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  a_warn_width: assert property ($rose(sdw_oe_reg) |-> sdw_oe_reg [*2])
    else $error("warning pulse too short");
  a_warn_off: assert property (st_reg == ST_OFF |-> !sdw_oe_reg)
    else $error("warning driven while off");
  a_rst_release: assert property ($fell(rst_oe_reg) |-> $past(st_reg) inside {ST_RDLY, ST_ON})
    else $error("reset released outside start-up end");
  a_rst_dflt: assert property (!fmode && st_reg == ST_ON && !off_evt |=> !rst_oe_reg)
    else $error("default mode reset asserted without turn-off");
  a_rst_seen: assert property (fmode && st_reg == ST_RDLY && seen_reg |=> rst_oe_reg)
    else $error("reset released after start-up fault");
  a_rst_fault: assert property (fmode && st_reg == ST_ON && flt_reg >= P_FLT_RST_CYC
    |=> rst_oe_reg)
    else $error("persistent fault did not assert reset");
  a_fault_off: assert property (fmode && flt_reg > P_FLT_OFF_CYC && st_reg == ST_ON
    |=> st_reg == ST_WARN)
    else $error("long fault did not power off");
  a_irq_set: assert property ($rose(flt) && !mask_reg |=> ##1 irq_oe_reg)
    else $error("unmasked fault missed interrupt");
  a_irq_hold: assert property (flag_reg && !(wr_hit(OFS_IRQ) && rif.wdata[B_IRQ_FLAG])
    |=> flag_reg)
    else $error("flag lost without clear");
  a_stby_pol: assert property (st_reg == ST_ON && st_next == ST_ON
    |=> stby_reg == ($past(lpr) ^ $past(lp_inv)))
    else $error("standby state wrong");
  a_flt_restart: assert property (!flt |=> flt_reg == 32'h0)
    else $error("fault timer not restarted");
  c_power_up: cover property (st_reg == ST_RDLY ##1 st_reg == ST_ON);
  c_shutdown: cover property (st_reg == ST_WARN ##1 st_reg == ST_OFF);
  c_irq_clear: cover property ($fell(flag_reg));
  c_fault_rst: cover property (fmode && st_reg == ST_ON && $rose(rst_oe_reg));
endmodule

// ===== logic/phc_pkg.sv
// Package: register map, field positions, timing and state codes
package phc_pkg;
  // Clock period of CLK in ns (250 MHz)
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Documented times in their own units
  localparam int unsigned T_RST_DLY_MS_X10 = 20;   // 2.0 ms least release delay
  localparam int unsigned T_FLT_RST_MS_X10 = 18;   // 1.8 ms fault to reset
  localparam int unsigned T_FLT_OFF_MS = 100;      // 100 ms fault to power off
  localparam int unsigned T_HOLD_OFF_S_X10 = 40;   // 4.0 s button hold
  localparam int unsigned T_SLOT_US = 500;         // Sequencer slot time
  localparam int unsigned F_SLOW_HZ = 32000;       // 32 kHz warning clock
  // Derived cycle counts; least times round up
  localparam int unsigned RST_DLY_CYC =
    (T_RST_DLY_MS_X10 * 100_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLT_RST_CYC = T_FLT_RST_MS_X10 * 100_000 / CLK_PERIOD_NS;
  localparam int unsigned FLT_OFF_CYC = T_FLT_OFF_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned HOLD_OFF_CYC = T_HOLD_OFF_S_X10 * 25_000_000;
  localparam int unsigned SLOT_CYC = T_SLOT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLOW_CYC =
    (1_000_000_000 / CLK_PERIOD_NS + F_SLOW_HZ - 1) / F_SLOW_HZ;
  // I2C slave address
  localparam logic [6:0] DEV_ADDR = 7'h08;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_SEQ = 8'h11;
  localparam logic [7:0] OFS_IRQ = 8'h12;
  localparam logic [7:0] OFS_MASK = 8'h13;
  localparam logic [7:0] OFS_FRM = 8'hE8;
  // Field positions
  localparam int unsigned B_EDGE_SEL = 0;   // Control and fuse word
  localparam int unsigned B_LP_INV = 1;
  localparam int unsigned B_FAULT_MODE = 2; // Fuse word only
  localparam int unsigned B_TRIAL = 7;      // Control register
  localparam int unsigned B_FRM_EN = 0;     // Fault reset mode register
  localparam int unsigned B_IRQ_FLAG = 0;   // Flag, write one to clear
  localparam int unsigned B_IRQ_LIVE = 1;   // Live fault level, read only
  localparam int unsigned B_MASK = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [4:0] RST_SEQ = 5'h00;
  localparam logic RST_FRM = 1'b0;
  localparam logic RST_MASK = 1'b0;
  // Power states
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_SEQ = 5'b00010,
    ST_RDLY = 5'b00100,
    ST_ON = 5'b01000,
    ST_WARN = 5'b10000
  } phc_state_e;
endpackage

// ===== logic/phc_reg_if.sv
// Interface between the serial register port and the control core
`timescale 1ns/1ns
interface phc_reg_if;
  logic scl;
  logic sda;
  logic sda_oe;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port (input scl, sda, rdata, output sda_oe, wr, addr, wdata);
  modport core (output scl, sda, rdata, input sda_oe, wr, addr, wdata);
endinterface

// ===== logic/phc_i2c_slave.sv
// Serial register port: two-wire slave with auto-incrementing pointer
`timescale 1ns/1ns
module phc_i2c_slave
  import phc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  phc_reg_if.port bus
);
  typedef enum logic [8:0] {
    I_IDLE = 9'h001, I_DEV = 9'h002, I_DACK = 9'h004, I_PTR = 9'h008,
    I_PACK = 9'h010, I_WR = 9'h020, I_WACK = 9'h040, I_RD = 9'h080,
    I_RACK = 9'h100
  } phc_i2c_e;

  phc_i2c_e st_reg, st_next;
  logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, wd_reg, wd_next;
  logic oe_reg, oe_next, wr_reg, wr_next, rw_reg, rw_next, nak_reg, nak_next;
  logic start, stop, rise, fall;

  // Inputs arrive already synchronised, so edges are safe to detect here
  assign start = bus.scl & scl_q_reg & sda_q_reg & ~bus.sda;
  assign stop = bus.scl & scl_q_reg & ~sda_q_reg & bus.sda;
  assign rise = bus.scl & ~scl_q_reg;
  assign fall = ~bus.scl & scl_q_reg;

  // Byte engine: shift on SCL rise, act and drive SDA on SCL fall
  always_comb begin
    st_next = st_reg;
    scl_q_next = bus.scl;
    sda_q_next = bus.sda;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    wd_next = wd_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    rw_next = rw_reg;
    nak_next = nak_reg;
    if (start) begin
      st_next = I_DEV;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop) begin
      st_next = I_IDLE;
      oe_next = 1'b0;
    end else if (rise && (st_reg inside {I_DEV, I_PTR, I_WR})) begin
      sh_next = {sh_reg[6:0], bus.sda};
      cnt_next = cnt_reg + 4'h1;
    end else if (rise && st_reg == I_RACK) begin
      nak_next = bus.sda;
    end else if (fall) begin
      unique case (st_reg)
        I_IDLE: st_next = I_IDLE;
        I_DEV: if (cnt_reg == 4'h8) begin
          // Only our own address is acknowledged
          st_next = (sh_reg[7:1] == DEV_ADDR) ? I_DACK : I_IDLE;
          oe_next = (sh_reg[7:1] == DEV_ADDR);
          rw_next = sh_reg[0];
        end
        I_PTR, I_WR: if (cnt_reg == 4'h8) begin
          st_next = (st_reg == I_PTR) ? I_PACK : I_WACK;
          oe_next = 1'b1;
          if (st_reg == I_PTR) begin
            ptr_next = sh_reg;
          end else begin
            wd_next = sh_reg;
            wr_next = 1'b1;
          end
        end
        I_DACK, I_PACK, I_WACK, I_RACK: begin
          cnt_next = 4'h0;
          if (st_reg == I_WACK) begin
            ptr_next = ptr_reg + 8'h01;
          end
          if ((st_reg == I_DACK && rw_reg) || (st_reg == I_RACK && !nak_reg)) begin
            st_next = I_RD;
            sh_next = bus.rdata;
            oe_next = ~bus.rdata[7];
            cnt_next = 4'h1;
          end else if (st_reg == I_RACK) begin
            st_next = I_IDLE;
            oe_next = 1'b0;
          end else begin
            st_next = (st_reg == I_DACK) ? I_PTR : I_WR;
            oe_next = 1'b0;
          end
        end
        I_RD: if (cnt_reg == 4'h8) begin
          st_next = I_RACK;
          oe_next = 1'b0;
          ptr_next = ptr_reg + 8'h01;
        end else begin
          sh_next = {sh_reg[6:0], 1'b0};
          oe_next = ~sh_reg[6];
          cnt_next = cnt_reg + 4'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= I_IDLE;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wd_reg <= 8'h00;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      rw_reg <= 1'b0;
      nak_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      wd_reg <= wd_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      rw_reg <= rw_next;
      nak_reg <= nak_next;
    end
  end

  assign bus.sda_oe = oe_reg;
  assign bus.wr = wr_reg;
  assign bus.addr = ptr_reg;
  assign bus.wdata = wd_reg;
endmodule

// ===== dv/phc_host_model.sv
// Host model: power button, standby pin and two-wire register master
`timescale 1ns/1ns
module phc_host_model
  import phc_pkg::*;
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  output logic power_on_request,
  output logic low_power_request
);
  int nacks = 0;

  // Pins idle: bus released, button up, standby request low
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
    power_on_request = 1'h0;
    low_power_request = 1'h0;
  end

  // Ten clocks per phase, well above the four the port needs to sync
  task automatic half();
    repeat (10) @(posedge clk);
    #1;
  endtask

  // Short pause after a fall so data never moves with the clock edge
  task automatic gap();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic put_bit(input logic b);
    gap();
    sda_pull = ~b;
    half();
    scl = 1'h1;
    half();
    scl = 1'h0;
  endtask

  // Sampled at the end of the high phase, just before the fall
  task automatic get_bit(output logic b);
    gap();
    sda_pull = 1'h0;
    half();
    scl = 1'h1;
    half();
    b = sda;
    scl = 1'h0;
  endtask

  // Serves as first and repeated start alike
  task automatic start();
    gap();
    sda_pull = 1'h0;
    half();
    scl = 1'h1;
    half();
    sda_pull = 1'h1;
    half();
    scl = 1'h0;
  endtask

  task automatic stop();
    gap();
    sda_pull = 1'h1;
    half();
    scl = 1'h1;
    half();
    sda_pull = 1'h0;
    half();
  endtask

  // One byte out, MSB first, then the slave's acknowledge
  task automatic send(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    if (a !== 1'h0) nacks++;
  endtask

  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d);
    start();
    send({DEV_ADDR, 1'h0});
    send(ptr);
    send(d);
    stop();
  endtask

  // Pointer set, repeated start, one byte read and a NACK to end
  task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d);
    start();
    send({DEV_ADDR, 1'h0});
    send(ptr);
    start();
    send({DEV_ADDR, 1'h1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'h1);
    stop();
  endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the power control core
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("CHECK FAILED at %0t: %s", $time, msg); \
    end \
  end
`define WAIT_UNTIL(c, lim) \
  begin \
    cnt = 0; \
    while (!(c) && cnt < (lim)) begin \
      @(posedge clk); \
      #1; \
      cnt++; \
    end \
  end
module tb_top
  import phc_pkg::*;
;
  // Short counts so the run stays small; expectations derive from these
  localparam int RST = 20, FRST = 15, FOFF = 60, HOLD = 50, SLOT = 10, SLOW = 8;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [7:0] fuse_cfg = 8'h00;
  logic fault_in = 1'h0;
  logic scl, sda_pull, pwr_on, low_pwr, sda_o, sda_oe, standby, powered;
  logic rst_o, rst_oe, warn_o, warn_oe, irq_o, irq_oe;
  logic [4:0] slot;
  int num_errors = 0;
  int n_compared = 0;
  int cnt, lows, t1;
  // Open-drain lines with pull-ups
  wire logic sda = sda_oe ? sda_o : ~sda_pull;
  wire logic host_rst_n = rst_oe ? rst_o : 1'h1;
  wire logic warn_n = warn_oe ? warn_o : 1'h1;
  wire logic irq_n = irq_oe ? irq_o : 1'h1;

  always #2 clk = ~clk;

  phc_ctrl #(.P_RST_DLY_CYC(RST), .P_FLT_RST_CYC(FRST), .P_FLT_OFF_CYC(FOFF),
    .P_HOLD_OFF_CYC(HOLD), .P_SLOT_CYC(SLOT), .P_SLOW_CYC(SLOW)) dut (
    .CLK(clk), .SRST(srst), .POWER_ON_REQUEST(pwr_on), .LOW_POWER_REQUEST(low_pwr),
    .FAULT_IN(fault_in), .FUSE_CFG(fuse_cfg), .FUSE_SEQ_LAST(5'h02), .SCL(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .HOST_RESET_OUT_N_O(rst_o),
    .HOST_RESET_OUT_N_OE(rst_oe), .SHUTDOWN_WARNING_N_O(warn_o),
    .SHUTDOWN_WARNING_N_OE(warn_oe), .FAULT_IRQ_OUT_N_O(irq_o),
    .FAULT_IRQ_OUT_N_OE(irq_oe), .REG_SLOT(slot), .STANDBY_ACTIVE(standby),
    .POWERED(powered));

  phc_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull),
    .power_on_request(pwr_on), .low_power_request(low_pwr));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Counts cycles in which the host reset line is held low
  task automatic watch(input int n);
    repeat (n) begin
      step(1);
      if (host_rst_n !== 1'h1) lows++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic t_reset();
    `CHK(powered, 1'h0, "powered after reset")
    `CHK(host_rst_n, 1'h0, "host reset after reset")
    `CHK(warn_n, 1'h1, "warning after reset")
    `CHK(irq_n, 1'h1, "irq after reset")
    $display("test reset done");
  endtask

  task automatic t_level_on();
    host.power_on_request = 1'h1;
    `WAIT_UNTIL(powered === 1'h1, 20)
    `CHK(powered, 1'h1, "level turn-on")
    `WAIT_UNTIL(slot === 5'h02, 100)
    `CHK(slot, 5'h02, "last slot from fuses")
    `CHK(host_rst_n, 1'h0, "reset held in sequence")
    `WAIT_UNTIL(host_rst_n === 1'h1, 100)
    `CHK(cnt >= RST && cnt <= RST + 3, 1'h1, "release delay")
    $display("test level on done");
  endtask

  // Default mode: a long fault only raises the interrupt
  task automatic t_default_fault();
    lows = 0;
    fault_in = 1'h1;
    watch(FOFF + 20);
    `CHK(lows, 0, "reset asserted by fault")
    `CHK(powered, 1'h1, "powered off by fault")
    `CHK(irq_n, 1'h0, "irq on fault")
    fault_in = 1'h0;
    host.reg_write(OFS_IRQ, 8'h01);
    step(10);
    `CHK(irq_n, 1'h1, "irq cleared")
    host.reg_write(OFS_MASK, 8'h01);
    fault_in = 1'h1;
    step(10);
    fault_in = 1'h0;
    step(10);
    `CHK(irq_n, 1'h1, "masked fault")
    host.reg_write(OFS_IRQ, 8'h01);
    host.reg_write(OFS_MASK, 8'h00);
    $display("test default fault done");
  endtask

  task automatic t_standby();
    host.low_power_request = 1'h1;
    step(10);
    `CHK(standby, 1'h1, "standby entered")
    host.low_power_request = 1'h0;
    step(10);
    `CHK(standby, 1'h0, "standby left")
    host.reg_write(OFS_SEQ, 8'h02);
    host.reg_write(OFS_CTRL, 8'h82);
    step(10);
    `CHK(standby, 1'h1, "inverted request low")
    host.low_power_request = 1'h1;
    step(10);
    `CHK(standby, 1'h0, "inverted request high")
    $display("test standby done");
  endtask

  task automatic t_level_off();
    host.power_on_request = 1'h0;
    `WAIT_UNTIL(warn_n === 1'h0, 20)
    `CHK(host_rst_n, 1'h0, "reset on turn-off")
    `WAIT_UNTIL(warn_n === 1'h1, 40)
    `CHK(cnt, SLOW, "warning width")
    step(30);
    `CHK(warn_n, 1'h1, "warning stays released")
    `CHK(powered, 1'h0, "off after low level")
    $display("test level off done");
  endtask

  // Fault mode chosen through the trial register set
  task automatic t_fault_mode();
    logic [7:0] d;
    host.reg_write(OFS_FRM, 8'h01);
    host.reg_read(OFS_FRM, d);
    `CHK(d, 8'h01, "mode register readback")
    host.reg_read(8'h40, d);
    `CHK(d, 8'h00, "unmapped read")
    `CHK(host.nacks, 0, "missing acknowledge")
    host.power_on_request = 1'h1;
    `WAIT_UNTIL(host_rst_n === 1'h1, 200)
    `CHK(host_rst_n, 1'h1, "fault-free start released")
    lows = 0;
    repeat (2) begin
      fault_in = 1'h1;
      watch(FRST - 5);
      fault_in = 1'h0;
      watch(5);
    end
    `CHK(lows, 0, "short faults reset")
    fault_in = 1'h1;
    `WAIT_UNTIL(host_rst_n === 1'h0, 40)
    t1 = cnt;
    `CHK(t1 >= FRST && t1 <= FRST + 6, 1'h1, "fault to reset")
    `WAIT_UNTIL(warn_n === 1'h0, 100)
    `CHK(t1 + cnt > FOFF && t1 + cnt <= FOFF + 8, 1'h1, "fault to off")
    `WAIT_UNTIL(warn_n === 1'h1, 40)
    `WAIT_UNTIL(powered === 1'h1, 20)
    `CHK(powered, 1'h1, "restart after fault off")
    `WAIT_UNTIL(warn_n === 1'h0 || host_rst_n === 1'h1, 300)
    `CHK(host_rst_n, 1'h0, "release after faulty start")
    `CHK(warn_n, 1'h0, "repeated power off")
    fault_in = 1'h0;
    `WAIT_UNTIL(host_rst_n === 1'h1, 300)
    `CHK(host_rst_n, 1'h1, "clean restart released")
    $display("test fault mode done");
  endtask

  task automatic t_edge_mode();
    host.power_on_request = 1'h0;
    `WAIT_UNTIL(warn_n === 1'h1 && powered === 1'h0, 100)
    host.reg_write(OFS_CTRL, 8'h83);
    host.power_on_request = 1'h1;
    step(20);
    `CHK(powered, 1'h0, "high level in edge mode")
    host.power_on_request = 1'h0;
    `WAIT_UNTIL(powered === 1'h1, 20)
    `CHK(powered, 1'h1, "falling edge turn-on")
    `WAIT_UNTIL(warn_n === 1'h0, 100)
    `CHK(cnt >= HOLD - 2 && cnt <= HOLD + 4, 1'h1, "hold to off")
    host.power_on_request = 1'h1;
    $display("test edge mode done");
  endtask

  // Fresh reset drops trial settings; fault mode now comes from the fuse word
  task automatic t_fuse_mode();
    fuse_cfg = 8'h04;
    srst = 1'h1;
    step(4);
    srst = 1'h0;
    fault_in = 1'h1;
    `WAIT_UNTIL(warn_n === 1'h0 || host_rst_n === 1'h1, 300)
    `CHK(host_rst_n, 1'h0, "fuse fault mode released reset")
    `CHK(warn_n, 1'h0, "fuse fault mode kept power")
    fault_in = 1'h0;
    $display("test fuse mode done");
  endtask

  // Main sequence: reset for 20 cycles, then the scenarios in order
  initial begin
    repeat (20) @(posedge clk);
    #1;
    srst = 1'h0;
    step(5);
    t_reset();
    t_level_on();
    t_default_fault();
    t_standby();
    t_level_off();
    t_fault_mode();
    t_edge_mode();
    t_fuse_mode();
    report_and_stop();
  end

  // Watchdog: the scenarios need well under a fifth of this span
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
